/* File: core/bcp_port.sv */
// Seven-pin general-purpose I/O port with AHB-Lite register access
//
// Operation
// - Write in output mode updates latch; latch drives the pin.
// - Latch holds last written value regardless of direction.
// - Write in input mode updates latch; driver stays off.
// - Read of output-mode pin returns latch, latch unchanged.
// - Read of input-mode pin returns pin level, latch unchanged.
// - Bit operations are whole-port 7-bit read-modify-write.
// - Operations on output ports work on latch and drive result.
// - Pull-up acts only in input mode; forced off in output mode.
// - Direction alone chooses pin level or latch on reads.
// - Seven pins, each bit individually configurable.
// - Per-pin falling and rising edge select bits.
// - Shared interrupt pin is a port pin after reset, no edge.
// - Shared debug pin starts as debug reset until enable cleared.
// - Debug pull-down connected while debug enabled, off when cleared.
// - Debug enable set makes shared pin debug reset regardless of select.
// - Direction bit 0 is output, 1 is input.
// - Function select 0 is port, 1 is alternate function.
// - Edge select decode: none, rising, falling, both.
`timescale 1ns/1ps
module bcp_port
  import bcp_pkg::*;
#(
  parameter int unsigned PINS = bcp_pkg::BCP_PINS
) (
  input  wire logic              hclk,          // System clock
  input  wire logic              hresetn,       // Async reset, active low
  input  wire logic              hsel,          // Slave select
  input  wire logic [31:0]       haddr,         // Byte address
  input  wire logic [1:0]        htrans,        // Transfer type
  input  wire logic              hwrite,        // Write not read
  input  wire logic [2:0]        hsize,         // Transfer size
  input  wire logic              hready,        // Bus ready in
  input  wire logic [31:0]       hwdata,        // Write data
  output logic      [31:0]       hrdata,        // Read data
  output logic                   hreadyout,     // Slave ready
  output logic                   hresp,         // Always OKAY
  input  wire logic [PINS-1:0]   pin_in,        // Pin levels
  output logic      [PINS-1:0]   pin_out,       // Output latch to pins
  output logic      [PINS-1:0]   pin_oe,        // Output driver enable
  output logic      [PINS-1:0]   pullup_en,     // Pull-up connect
  output logic                   debug_pulldown, // Debug pin pull-down connect
  output logic                   debug_reset_pin, // Debug reset level to debug unit
  output logic      [PINS-1:0]   alt_in,        // Pin levels to alternate functions
  output logic      [PINS-1:0]   alt_sel,       // Effective alternate selection
  output logic      [PINS-1:0]   mode_sel,      // Control mode 1/2 select
  output logic      [PINS-1:0]   mode_ext_sel,  // Control mode extension select
  output logic      [PINS-1:0]   irq_edge       // Edge pulse per pin
);
  import bcp_pkg::*;

  typedef struct packed {
    logic [PINS-1:0] latch;
    logic [PINS-1:0] pin_direction_reg;
    logic [PINS-1:0] pin_function_select_reg;
    logic [PINS-1:0] control_mode_select_reg;
    logic [PINS-1:0] control_mode_ext_select_reg;
    logic [PINS-1:0] pullup_enable_reg;
    logic [PINS-1:0] falling_edge_select_reg;
    logic [PINS-1:0] rising_edge_select_reg;
    logic [PINS-1:0] edge_seen;
    logic            debug_enable_bit;
    logic            wr_pend;
    logic [7:0]      wr_addr;
    logic [31:0]     rdata;
  } bcp_state_s;

  bcp_state_s st_reg;
  bcp_state_s st_next;

  logic [PINS-1:0] pin_sync;
  logic [PINS-1:0] edge_pulse;
  logic [PINS-1:0] port_view;
  logic [PINS-1:0] eff_alt;
  logic            take;
  logic [7:0]      a_off;

  // Per-pin synchroniser and edge detector
  for (genvar i = 0; i < PINS; i++) begin : g_pin
    bcp_edge_detect u_edge (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .pin_in   (pin_in[i]),
      .fall_sel (st_reg.falling_edge_select_reg[i]),
      .rise_sel (st_reg.rising_edge_select_reg[i]),
      .level    (pin_sync[i]),
      .edge_hit (edge_pulse[i])
    );
  end

  assign take  = hsel & hready & htrans[1];
  assign a_off = haddr[7:0];

  // Direction alone picks latch or pin level
  assign port_view = (st_reg.pin_direction_reg & pin_sync)
                   | (~st_reg.pin_direction_reg & st_reg.latch);

  // Debug enable overrides the select on the shared debug pin
  always_comb begin
    eff_alt = st_reg.pin_function_select_reg;
    eff_alt[BCP_DBG_BIT] = st_reg.pin_function_select_reg[BCP_DBG_BIT]
                         | st_reg.debug_enable_bit;
  end

  always_comb begin
    st_next      = st_reg;
    st_next.edge_seen = st_reg.edge_seen | edge_pulse;
    st_next.wr_pend = take & hwrite;
    st_next.wr_addr = a_off;
    if (take && !hwrite) begin
      unique case (a_off)
        BCP_OFF_DATA:   st_next.rdata = {25'h0, port_view};
        BCP_OFF_DIR:    st_next.rdata = {25'h0, st_reg.pin_direction_reg};
        BCP_OFF_FUNC:   st_next.rdata = {25'h0, st_reg.pin_function_select_reg};
        BCP_OFF_MODE:   st_next.rdata = {17'h0, st_reg.control_mode_ext_select_reg,
                                         1'b0, st_reg.control_mode_select_reg};
        BCP_OFF_PULLUP: st_next.rdata = {25'h0, st_reg.pullup_enable_reg};
        BCP_OFF_FALL:   st_next.rdata = {25'h0, st_reg.falling_edge_select_reg};
        BCP_OFF_RISE:   st_next.rdata = {25'h0, st_reg.rising_edge_select_reg};
        BCP_OFF_DEBUG:  st_next.rdata = {31'h0, st_reg.debug_enable_bit};
        BCP_OFF_EDGE:   st_next.rdata = {25'h0, st_reg.edge_seen};
        default:        st_next.rdata = 32'h0000_0000;
      endcase
    end
    if (st_reg.wr_pend) begin
      unique case (st_reg.wr_addr)
        // Whole-port write; latch takes the value in either direction
        BCP_OFF_DATA:   st_next.latch = hwdata[PINS-1:0];
        BCP_OFF_DIR:    st_next.pin_direction_reg = hwdata[PINS-1:0];
        BCP_OFF_FUNC:   st_next.pin_function_select_reg = hwdata[PINS-1:0];
        BCP_OFF_MODE: begin
          st_next.control_mode_select_reg     = hwdata[PINS-1:0];
          st_next.control_mode_ext_select_reg = hwdata[8+PINS-1:8];
        end
        BCP_OFF_PULLUP: st_next.pullup_enable_reg = hwdata[PINS-1:0];
        BCP_OFF_FALL:   st_next.falling_edge_select_reg = hwdata[PINS-1:0];
        BCP_OFF_RISE:   st_next.rising_edge_select_reg = hwdata[PINS-1:0];
        BCP_OFF_DEBUG:  st_next.debug_enable_bit = hwdata[0];
        // Write-one-to-clear; a new edge in the same cycle wins
        BCP_OFF_EDGE:   st_next.edge_seen = (st_reg.edge_seen & ~hwdata[PINS-1:0])
                                          | edge_pulse;
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg.latch                       <= BCP_RST_DATA;
      st_reg.pin_direction_reg           <= BCP_RST_DIR;
      st_reg.pin_function_select_reg     <= BCP_RST_ZERO;
      st_reg.control_mode_select_reg     <= BCP_RST_ZERO;
      st_reg.control_mode_ext_select_reg <= BCP_RST_ZERO;
      st_reg.pullup_enable_reg           <= BCP_RST_ZERO;
      st_reg.falling_edge_select_reg     <= BCP_RST_ZERO;
      st_reg.rising_edge_select_reg      <= BCP_RST_ZERO;
      st_reg.edge_seen                   <= BCP_RST_ZERO;
      st_reg.debug_enable_bit            <= BCP_RST_DEBUG_EN;
      st_reg.wr_pend                     <= 1'b0;
      st_reg.wr_addr                     <= 8'h00;
      st_reg.rdata                       <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hrdata    = st_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Driver on only for output-mode port pins
  assign pin_out = st_reg.latch;
  assign pin_oe  = ~st_reg.pin_direction_reg & ~eff_alt;
  assign pullup_en = st_reg.pullup_enable_reg & st_reg.pin_direction_reg;
  assign debug_pulldown  = st_reg.debug_enable_bit;
  assign debug_reset_pin = st_reg.debug_enable_bit & pin_sync[BCP_DBG_BIT];
  assign alt_in    = pin_sync;
  assign alt_sel   = eff_alt;
  assign mode_sel  = st_reg.control_mode_select_reg;
  assign mode_ext_sel = st_reg.control_mode_ext_select_reg;
  assign irq_edge  = edge_pulse;

  chk_pullup_output_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.pin_direction_reg[0] == 1'b0) |-> (pullup_en[0] == 1'b0))
    else $error("Pull-up on in output mode");

  chk_latch_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && hwrite && a_off == BCP_OFF_DATA) ##1 1'b1 |=> (pin_out == $past(hwdata[PINS-1:0])))
    else $error("Latch did not take written data");

  chk_latch_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !(st_reg.wr_pend && st_reg.wr_addr == BCP_OFF_DATA) |=> $stable(pin_out))
    else $error("Latch changed without a write");

  chk_input_no_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    (pin_oe & st_reg.pin_direction_reg) == '0)
    else $error("Driver on in input mode");

  chk_read_view: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && a_off == BCP_OFF_DATA && !st_reg.wr_pend)
    |=> (hrdata[PINS-1:0] == $past(port_view)))
    else $error("Data read not chosen by direction");

  chk_debug_pulldown: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.wr_pend && st_reg.wr_addr == BCP_OFF_DEBUG && !hwdata[0]) |=> !debug_pulldown)
    else $error("Pull-down still on after debug disable");

  chk_debug_override: assert property (@(posedge hclk) disable iff (!hresetn)
    st_reg.debug_enable_bit |-> (alt_sel[BCP_DBG_BIT] && !pin_oe[BCP_DBG_BIT]))
    else $error("Debug pin not held as debug reset");

  chk_nmi_reset_port: assert property (@(posedge hclk)
    $rose(hresetn) |-> (!alt_sel[BCP_NMI_BIT] && st_reg.falling_edge_select_reg == '0
                        && st_reg.rising_edge_select_reg == '0))
    else $error("Shared interrupt pin not a plain port after reset");

  chk_debug_reset_val: assert property (@(posedge hclk)
    $rose(hresetn) |-> debug_pulldown)
    else $error("Debug enable not set after reset");

  // Register writes land at the end of their data phase
  chk_dir_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.wr_pend && st_reg.wr_addr == BCP_OFF_DIR)
    |=> (st_reg.pin_direction_reg == $past(hwdata[PINS-1:0])))
    else $error("Direction write lost");

  chk_func_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.wr_pend && st_reg.wr_addr == BCP_OFF_FUNC)
    |=> (st_reg.pin_function_select_reg == $past(hwdata[PINS-1:0])))
    else $error("Function select write lost");

  chk_mode_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.wr_pend && st_reg.wr_addr == BCP_OFF_MODE)
    |=> (mode_sel == $past(hwdata[PINS-1:0])
         && mode_ext_sel == $past(hwdata[8+PINS-1:8])))
    else $error("Control mode write lost");

  chk_pullup_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.wr_pend && st_reg.wr_addr == BCP_OFF_PULLUP)
    |=> (st_reg.pullup_enable_reg == $past(hwdata[PINS-1:0])))
    else $error("Pull-up enable write lost");

  chk_fall_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.wr_pend && st_reg.wr_addr == BCP_OFF_FALL)
    |=> (st_reg.falling_edge_select_reg == $past(hwdata[PINS-1:0])))
    else $error("Falling edge select write lost");

  chk_rise_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.wr_pend && st_reg.wr_addr == BCP_OFF_RISE)
    |=> (st_reg.rising_edge_select_reg == $past(hwdata[PINS-1:0])))
    else $error("Rising edge select write lost");

  chk_debug_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.wr_pend && st_reg.wr_addr == BCP_OFF_DEBUG)
    |=> (st_reg.debug_enable_bit == $past(hwdata[0])))
    else $error("Debug enable write lost");

  // Read data shows register contents as they stood in the address phase
  chk_read_dir: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && a_off == BCP_OFF_DIR)
    |=> (hrdata[PINS-1:0] == $past(st_reg.pin_direction_reg)))
    else $error("Direction read mismatch");

  chk_read_func: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && a_off == BCP_OFF_FUNC)
    |=> (hrdata[PINS-1:0] == $past(st_reg.pin_function_select_reg)))
    else $error("Function select read mismatch");

  chk_read_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && a_off == BCP_OFF_MODE)
    |=> (hrdata[PINS-1:0] == $past(st_reg.control_mode_select_reg)
         && hrdata[8+PINS-1:8] == $past(st_reg.control_mode_ext_select_reg)))
    else $error("Control mode read mismatch");

  chk_read_pullup: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && a_off == BCP_OFF_PULLUP)
    |=> (hrdata[PINS-1:0] == $past(st_reg.pullup_enable_reg)))
    else $error("Pull-up enable read mismatch");

  chk_read_fall: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && a_off == BCP_OFF_FALL)
    |=> (hrdata[PINS-1:0] == $past(st_reg.falling_edge_select_reg)))
    else $error("Falling edge select read mismatch");

  chk_read_rise: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && a_off == BCP_OFF_RISE)
    |=> (hrdata[PINS-1:0] == $past(st_reg.rising_edge_select_reg)))
    else $error("Rising edge select read mismatch");

  chk_read_debug: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && a_off == BCP_OFF_DEBUG)
    |=> (hrdata[0] == $past(st_reg.debug_enable_bit)))
    else $error("Debug enable read mismatch");

  chk_rdata_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !(take && !hwrite)
    |=> $stable(hrdata))
    else $error("Read data changed without a read");

  chk_read_no_side: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && a_off == BCP_OFF_DATA && !st_reg.wr_pend)
    |=> $stable(st_reg.latch))
    else $error("Data read disturbed the latch");

  // Sticky edge flags: a new edge beats a clear in the same cycle
  chk_edge_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (edge_pulse != '0)
    |=> ((st_reg.edge_seen & $past(edge_pulse)) == $past(edge_pulse)))
    else $error("Edge pulse not recorded");

  chk_edge_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (edge_pulse == '0 && !(st_reg.wr_pend && st_reg.wr_addr == BCP_OFF_EDGE))
    |=> $stable(st_reg.edge_seen))
    else $error("Edge flags changed with no edge or clear");

  chk_edge_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.wr_pend && st_reg.wr_addr == BCP_OFF_EDGE && edge_pulse == '0)
    |=> ((st_reg.edge_seen & $past(hwdata[PINS-1:0])) == '0))
    else $error("Edge flag not cleared");

  // Pin side
  chk_output_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    (~st_reg.pin_direction_reg & ~alt_sel & ~pin_oe) == '0)
    else $error("Output-mode port pin not driven");

  chk_pullup_input: assert property (@(posedge hclk) disable iff (!hresetn)
    pullup_en == (st_reg.pullup_enable_reg & st_reg.pin_direction_reg))
    else $error("Pull-up not following enable in input mode");

  chk_debug_pin_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !st_reg.debug_enable_bit |-> !debug_reset_pin)
    else $error("Debug reset active with debug disabled");

  chk_debug_pin_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    st_reg.debug_enable_bit |-> (debug_reset_pin == pin_sync[BCP_DBG_BIT]))
    else $error("Debug reset not following its pin");

  chk_alt_port: assert property (@(posedge hclk) disable iff (!hresetn)
    !st_reg.debug_enable_bit |-> (alt_sel == st_reg.pin_function_select_reg))
    else $error("Alternate selection not from function select");
endmodule // bcp_port

/* File: include/bcp_pkg.sv */
// Package of register offsets, field positions and reset values for the I/O port block
package bcp_pkg;
  localparam int unsigned BCP_PINS       = 7;
  localparam int unsigned BCP_ADDR_W     = 8;
  localparam logic [7:0] BCP_OFF_DATA     = 8'h00;
  localparam logic [7:0] BCP_OFF_DIR      = 8'h04;
  localparam logic [7:0] BCP_OFF_FUNC     = 8'h08;
  localparam logic [7:0] BCP_OFF_MODE     = 8'h0C;
  localparam logic [7:0] BCP_OFF_PULLUP   = 8'h10;
  localparam logic [7:0] BCP_OFF_FALL     = 8'h14;
  localparam logic [7:0] BCP_OFF_RISE     = 8'h18;
  localparam logic [7:0] BCP_OFF_DEBUG    = 8'h1C;
  localparam logic [7:0] BCP_OFF_EDGE     = 8'h20;
  localparam logic [6:0] BCP_RST_DATA     = 7'h00;
  localparam logic [6:0] BCP_RST_DIR      = 7'h7F;
  localparam logic [6:0] BCP_RST_ZERO     = 7'h00;
  localparam logic       BCP_RST_DEBUG_EN = 1'b1;
  localparam int unsigned BCP_NMI_BIT     = 2;
  localparam int unsigned BCP_DBG_BIT     = 5;
  localparam int unsigned BCP_IRQ_LO      = 2;
  localparam logic [1:0] BCP_HTRANS_NONSEQ = 2'b10;
endpackage

/* File: core/bcp_edge_detect.sv */
// One pin's synchroniser and selectable edge detector
`timescale 1ns/1ps
module bcp_edge_detect (
  input  wire logic hclk,      // System clock
  input  wire logic hresetn,   // Async reset, active low
  input  wire logic pin_in,    // Raw pin level
  input  wire logic fall_sel,  // Falling edge enable
  input  wire logic rise_sel,  // Rising edge enable
  output logic      level,     // Synchronised level
  output logic      edge_hit   // One-cycle edge pulse
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic hit;
  } bcp_sync_s;
  bcp_sync_s st_reg;
  bcp_sync_s st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.meta = pin_in;
    st_next.sync = st_reg.meta;
    st_next.last = st_reg.sync;
    st_next.hit  = (rise_sel & st_reg.sync & ~st_reg.last)
                 | (fall_sel & ~st_reg.sync & st_reg.last);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level    = st_reg.sync;
  assign edge_hit = st_reg.hit;

  chk_no_edge_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (!$past(fall_sel) && !$past(rise_sel)) |-> !edge_hit)
    else $error("Edge reported with no edge selected");
endmodule // bcp_edge_detect

/* File: sim/bcp_pin_env.sv */
// Pad model: resolves each pin from port driver, outside drivers and pulls
`timescale 1ns/1ps
module bcp_pin_env (
  input  wire logic       hclk,           // System clock
  input  wire logic [6:0] pin_out,        // Port latch
  input  wire logic [6:0] pin_oe,         // Port driver enable
  input  wire logic [6:0] pullup_en,      // Pull-up connect
  input  wire logic       debug_pulldown, // Debug pin pull-down
  input  wire logic [6:0] ext_drv,        // Level from outside party
  input  wire logic [6:0] ext_en,         // Outside party drives
  output logic      [6:0] pin_in          // Resolved pad level
);
  logic [6:0] float_pat = 7'h2A;
  // A floating pad wanders instead of keeping its last level
  always @(posedge hclk) begin
    float_pat <= ~float_pat;
  end
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_drv[i];
      end else if (pullup_en[i]) begin
        pin_in[i] = 1'b1;
      end else if (i == 5 && debug_pulldown) begin
        pin_in[i] = 1'b0;
      end else begin
        pin_in[i] = float_pat[i];
      end
    end
  end
endmodule // bcp_pin_env

/* File: sim/bcp_port_tb.sv */
// Self-checking bench for the I/O port block over AHB-Lite
`timescale 1ns/1ps
module bcp_port_tb;
  import bcp_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, debug_pulldown, debug_reset_pin;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [6:0]  pin_in, pin_out, pin_oe, pullup_en, alt_in, alt_sel, mode_sel, mode_ext_sel;
  logic [6:0]  irq_edge, ext_drv, ext_en;
  int          fail_count, checks_done, edge_cnt;

  bcp_port bcp_port_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
    .debug_pulldown(debug_pulldown), .debug_reset_pin(debug_reset_pin), .alt_in(alt_in),
    .alt_sel(alt_sel), .mode_sel(mode_sel), .mode_ext_sel(mode_ext_sel), .irq_edge(irq_edge));
  bcp_pin_env bcp_pin_env_inst (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .debug_pulldown(debug_pulldown), .ext_drv(ext_drv),
    .ext_en(ext_en), .pin_in(pin_in));

  always #2.5 hclk = ~hclk;
  always @(posedge hclk) begin
    if (irq_edge[3] === 1'b1) edge_cnt <= edge_cnt + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Address phase held until hready, then data phase held until hready
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= BCP_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0000_0000);
    chk(v, exp);
  endtask
  task automatic settle();
    repeat (3) @(posedge hclk);
    #1;
  endtask
  task automatic pin3(input logic lvl, input int exp);
    int base;
    @(posedge hclk);
    ext_drv[3] <= lvl;
    base = edge_cnt;
    repeat (6) @(posedge hclk);
    #1;
    chk(edge_cnt - base, exp);
  endtask
  task automatic conclude();
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #20000;
    fail_count++;
    conclude();
  end

  initial begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
    hsize = 3'b010; hwdata = 0; fail_count = 0; checks_done = 0;
    ext_drv = 7'h00;
    ext_en = 7'h7F;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk(pin_oe, 32'h0000_0000);
    chk(alt_sel, 32'h0000_0020);
    chk(debug_pulldown, 32'h0000_0001);
    chk(debug_reset_pin, 32'h0000_0000);
    chk(hresp, 32'h0000_0000);
    rd_chk(BCP_OFF_DIR, 32'h0000_007F);
    rd_chk(BCP_OFF_DEBUG, 32'h0000_0001);
    @(posedge hclk);
    ext_drv <= 7'h4A;
    bus(BCP_OFF_DATA, 1'b1, 32'h0000_0055);
    settle();
    chk(pin_oe, 32'h0000_0000);
    chk(pin_out, 32'h0000_0055);
    rd_chk(BCP_OFF_DATA, 32'h0000_004A);
    bus(BCP_OFF_DIR, 1'b1, 32'h0000_000F);
    settle();
    chk(pin_oe, 32'h0000_0050);
    chk(alt_in, 32'h0000_005A);
    rd_chk(BCP_OFF_DATA, 32'h0000_005A);
    bus(BCP_OFF_PULLUP, 1'b1, 32'h0000_007F);
    settle();
    chk(pullup_en, 32'h0000_000F);
    bus(BCP_OFF_DATA, 1'b0, 32'h0000_0000);
    bus(BCP_OFF_DATA, 1'b1, v & 32'h0000_006F);
    settle();
    chk(pin_out, 32'h0000_004A);
    bus(BCP_OFF_MODE, 1'b1, 32'h0000_005A);
    settle();
    chk(mode_sel, 32'h0000_005A);
    chk(mode_ext_sel, 32'h0000_0000);
    rd_chk(BCP_OFF_MODE, 32'h0000_005A);
    bus(BCP_OFF_DEBUG, 1'b1, 32'h0000_0000);
    settle();
    chk(debug_pulldown, 32'h0000_0000);
    chk(alt_sel, 32'h0000_0000);
    chk(debug_reset_pin, 32'h0000_0000);
    chk(pin_oe, 32'h0000_0070);
    bus(BCP_OFF_FUNC, 1'b1, 32'h0000_0014);
    settle();
    chk(alt_sel, 32'h0000_0014);
    chk(pin_oe, 32'h0000_0060);
    bus(8'h40, 1'b1, 32'h0000_FFFF);
    chk(pin_out, 32'h0000_004A);
    rd_chk(8'h40, 32'h0000_0000);
    rd_chk(BCP_OFF_FUNC, 32'h0000_0014);
    pin3(1'b1, 0);
    pin3(1'b0, 0);
    for (int c = 0; c < 4; c++) begin
      bus(BCP_OFF_FALL, 1'b1, 32'(c >> 1) << 3);
      bus(BCP_OFF_RISE, 1'b1, 32'(c & 1) << 3);
      pin3(1'b1, c & 1);
      pin3(1'b0, c >> 1);
    end
    rd_chk(BCP_OFF_EDGE, 32'h0000_0008);
    bus(BCP_OFF_EDGE, 1'b1, 32'h0000_0008);
    rd_chk(BCP_OFF_EDGE, 32'h0000_0000);
    // Second reset in mid-run must restore port defaults
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk(alt_sel, 32'h0000_0020);
    chk(pin_oe, 32'h0000_0000);
    rd_chk(BCP_OFF_FALL, 32'h0000_0000);
    rd_chk(BCP_OFF_RISE, 32'h0000_0000);
    rd_chk(BCP_OFF_DEBUG, 32'h0000_0001);
    conclude();
  end
endmodule // bcp_port_tb
